//--- core/spe_pkg.sv
// Constants and types shared by the serial EEPROM write block
package spe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 5000000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int         ADDR_BITS   = 11;
  localparam int         PAGE_BITS   = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Serial command codes
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_WRDIS = 8'h04;
  localparam logic [7:0] CMD_RDST  = 8'h05;
  localparam logic [7:0] CMD_WR_EN = 8'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_ARR_ADDR = 8'h10;
  localparam logic [7:0] OFS_ARR_DATA = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int         CTRL_BP_LO_BIT  = 0;
  localparam int         CTRL_BP_HI_BIT  = 1;
  localparam int         CTRL_SWD_BIT    = 7;
  localparam int         STS_BUSY_BIT    = 0;
  localparam int         STS_WEN_BIT     = 1;
  localparam int         INT_DONE_BIT    = 0;
  localparam int         INT_REFUSE_BIT  = 1;
  localparam logic       CTRL_RESET      = 1'b0;
  localparam logic [1:0] INT_MASK_RESET  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spe_pins_t;

  localparam spe_pins_t PINS_IDLE = 3'h2;

  typedef struct packed {
    logic       status_write_disable;
    logic [2:0] zero;
    logic       block_protect_hi;
    logic       block_protect_lo;
    logic       write_enable_latch;
    logic       write_in_progress_flag;
  } spe_status_t;

  typedef enum {F_IDLE, F_CMD, F_ADDR_HI, F_ADDR_LO, F_DATA, F_STAT,
                F_SKIP} spe_frame_t;

  typedef enum {P_IDLE, P_COPY, P_WAIT} spe_prog_t;

endpackage

//--- core/spe_sync.sv
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/10ps
module spe_sync
  import spe_pkg::*;
#(
  parameter int             W   = 3,
  parameter logic [W-1:0]   RST = '0
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_reg[i] <= RST[i];
        q[i]        <= RST[i];
      end else begin
        meta_reg[i] <= d[i];
        q[i]        <= meta_reg[i];
      end
    end
  end

endmodule

//--- core/spe_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/10ps
module spe_mem
  import spe_pkg::*;
#(
  parameter int              AW   = 5,
  parameter int              DW   = 8,
  parameter logic [DW-1:0]   INIT = '1
)(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Delivered state of every byte
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = INIT;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

//--- core/spe_top.sv
// Serial EEPROM write path with AHB-Lite control registers
`timescale 1ns/10ps

// How it works
// - Select low, then command, address and data bytes are sampled in.
// - Select rising on a byte boundary ends the write; one byte is fine.
// - Accepted write runs a fixed timed cycle, then in-progress drops to 0.
// - Bytes keep loading while select is low; one cycle programs them.
// - Each data byte advances only the in-page address bits.
// - 32-byte pages; overflow wraps to page start, later bytes win.
// - Write ignored unless the enable latch was set beforehand.
// - Write command refused while a programming cycle runs.
// - Select rising mid-byte discards the whole write.
// - Write to a page inside the block-protected region is refused.
// - Every array byte starts at FFh.
// - Status-write-disable and both block-protect bits start at 0.
// - Sixteen address bits arrive; only the low eleven pick a byte.
// - In-progress reads 1 all cycle; status stays readable meanwhile.
// - Enable command sets the latch for the next write unless sent while busy or ended mid-byte.
module spe_top
  import spe_pkg::*;
#(
  parameter int          AW          = ADDR_BITS,
  parameter int unsigned PROG_CYC    = PROG_CYCLES
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso_o,
  output logic             miso_oe_n,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  spe_pins_t         pins_raw;
  spe_pins_t         pins_s;
  spe_frame_t        f_reg;
  spe_frame_t        f_next;
  spe_prog_t         p_reg;
  spe_status_t       status_byte;
  logic              sclk_d_reg;
  logic              rise;
  logic              fall;
  logic [2:0]        bit_cnt_reg;
  logic [6:0]        rx_reg;
  logic [7:0]        rx_byte;
  logic              byte_done;
  logic [7:0]        cmd_reg;
  logic [7:0]        cmd_next;
  logic [7:0]        addr_hi_reg;
  logic [7:0]        addr_hi_next;
  logic [AW-1:0]     addr_reg;
  logic [AW-1:0]     addr_next;
  logic [AW-1:0]     new_addr;
  logic [4:0]        off_reg;
  logic [4:0]        off_next;
  logic [31:0]       valid_reg;
  logic [31:0]       valid_next;
  logic              have_reg;
  logic              have_next;
  logic              prot;
  logic              buf_we;
  logic              start_prog;
  logic              refuse_evt;
  logic              wen_set;
  logic              wen_clr;
  logic              wen_reg;
  logic              busy;
  logic              done_evt;
  logic [5:0]        copy_idx_reg;
  logic [4:0]        copy_off;
  logic [31:0]       prog_cnt_reg;
  logic [7:0]        buf_rdata;
  logic              arr_we;
  logic [7:0]        arr_rdata;
  logic [7:0]        out_sh_reg;
  logic [2:0]        out_cnt_reg;
  logic              bp_lo_reg;
  logic              bp_hi_reg;
  logic              swd_reg;
  logic [1:0]        int_stat_reg;
  logic [1:0]        int_mask_reg;
  logic [1:0]        int_set;
  logic [AW-1:0]     arr_addr_reg;
  logic              ap;
  logic              wr_pend_reg;
  logic [7:0]        wr_ofs_reg;
  logic [31:0]       rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edges
  assign pins_raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

  spe_sync #(.W(3), .RST(PINS_IDLE)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign rise      = pins_s.sclk & ~sclk_d_reg;
  assign fall      = ~pins_s.sclk & sclk_d_reg;
  assign rx_byte   = {rx_reg, pins_s.mosi};
  assign byte_done = rise && (f_reg != F_IDLE) && (bit_cnt_reg == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Address and protection
  assign new_addr = AW'({addr_hi_reg, rx_byte});
  assign prot = (bp_hi_reg & bp_lo_reg) |
                (bp_hi_reg & ~bp_lo_reg & new_addr[AW-1]) |
                (~bp_hi_reg & bp_lo_reg & (&new_addr[AW-1:AW-2]));

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder
  always_comb begin
    f_next       = f_reg;
    cmd_next     = cmd_reg;
    addr_hi_next = addr_hi_reg;
    addr_next    = addr_reg;
    off_next     = off_reg;
    valid_next   = valid_reg;
    have_next    = have_reg;
    buf_we       = 1'b0;
    start_prog   = 1'b0;
    refuse_evt   = 1'b0;
    wen_set      = 1'b0;
    wen_clr      = 1'b0;
    if (f_reg == F_IDLE) begin
      if (!pins_s.cs_n) begin
        f_next = F_CMD;
      end
    end else if (pins_s.cs_n) begin
      f_next = F_IDLE;
      if (f_reg == F_DATA) begin
        if (have_reg && bit_cnt_reg == 3'h0) begin
          start_prog = 1'b1;
        end else begin
          refuse_evt = 1'b1;
        end
      end
      if (f_reg == F_SKIP && bit_cnt_reg == 3'h0 && !busy) begin
        wen_set = (cmd_reg == CMD_WR_EN);
        wen_clr = (cmd_reg == CMD_WRDIS);
      end
    end else if (byte_done) begin
      case (f_reg)
        F_CMD: begin
          cmd_next = rx_byte;
          if (rx_byte == CMD_WRITE) begin
            if (wen_reg && !busy) begin
              f_next = F_ADDR_HI;
            end else begin
              refuse_evt = 1'b1;
              f_next     = F_SKIP;
            end
          end else if (rx_byte == CMD_RDST) begin
            f_next = F_STAT;
          end else begin
            f_next = F_SKIP;
          end
        end
        F_ADDR_HI: begin
          addr_hi_next = rx_byte;
          f_next       = F_ADDR_LO;
        end
        F_ADDR_LO: begin
          addr_next  = new_addr;
          off_next   = new_addr[PAGE_BITS-1:0];
          valid_next = 32'h0000_0000;
          have_next  = 1'b0;
          if (prot) begin
            refuse_evt = 1'b1;
            f_next     = F_SKIP;
          end else begin
            f_next = F_DATA;
          end
        end
        F_DATA: begin
          buf_we              = 1'b1;
          valid_next[off_reg] = 1'b1;
          off_next            = off_reg + 5'h01;
          have_next           = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_reg       <= F_IDLE;
      sclk_d_reg  <= 1'b0;
      bit_cnt_reg <= 3'h0;
      rx_reg      <= 7'h00;
      cmd_reg     <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_reg    <= '0;
      off_reg     <= 5'h00;
      valid_reg   <= 32'h0000_0000;
      have_reg    <= 1'b0;
    end else begin
      f_reg       <= f_next;
      sclk_d_reg  <= pins_s.sclk;
      bit_cnt_reg <= (f_reg == F_IDLE) ? 3'h0
                   : bit_cnt_reg + {2'h0, rise};
      rx_reg      <= rise ? rx_byte[6:0] : rx_reg;
      cmd_reg     <= cmd_next;
      addr_hi_reg <= addr_hi_next;
      addr_reg    <= addr_next;
      off_reg     <= off_next;
      valid_reg   <= valid_next;
      have_reg    <= have_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status shift-out
  assign status_byte = '{status_write_disable:   swd_reg,
                         zero:                   3'h0,
                         block_protect_hi:       bp_hi_reg,
                         block_protect_lo:       bp_lo_reg,
                         write_enable_latch:     wen_reg,
                         write_in_progress_flag: busy};
  assign miso_oe_n = (f_reg != F_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_sh_reg  <= 8'h00;
      out_cnt_reg <= 3'h0;
      miso_o      <= 1'b0;
    end else if (f_next != F_STAT) begin
      out_sh_reg  <= status_byte;
      out_cnt_reg <= 3'h0;
      miso_o      <= 1'b0;
    end else if (fall) begin
      miso_o      <= out_sh_reg[7];
      out_sh_reg  <= (out_cnt_reg == 3'h7) ? status_byte
                   : {out_sh_reg[6:0], 1'b0};
      out_cnt_reg <= out_cnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer, array and programming cycle
  assign busy     = (p_reg != P_IDLE);
  assign copy_off = 5'(copy_idx_reg - 6'h01);
  assign arr_we   = (p_reg == P_COPY) && (copy_idx_reg != 6'h00)
                    && valid_reg[copy_off];
  assign done_evt = (p_reg == P_WAIT) && (prog_cnt_reg == 32'(PROG_CYC - 1));

  spe_mem #(.AW(PAGE_BITS), .DW(8), .INIT(ERASED_BYTE)) u_page (
    .clk   (hclk),
    .we    (buf_we),
    .waddr (off_reg),
    .wdata (rx_byte),
    .raddr (copy_idx_reg[4:0]),
    .rdata (buf_rdata)
  );

  spe_mem #(.AW(AW), .DW(8), .INIT(ERASED_BYTE)) u_array (
    .clk   (hclk),
    .we    (arr_we),
    .waddr ({addr_reg[AW-1:PAGE_BITS], copy_off}),
    .wdata (buf_rdata),
    .raddr (arr_addr_reg),
    .rdata (arr_rdata)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_reg        <= P_IDLE;
      copy_idx_reg <= 6'h00;
      prog_cnt_reg <= 32'h0000_0000;
    end else begin
      case (p_reg)
        P_IDLE: begin
          copy_idx_reg <= 6'h00;
          prog_cnt_reg <= 32'h0000_0000;
          if (start_prog) begin
            p_reg <= P_COPY;
          end
        end
        P_COPY: begin
          copy_idx_reg <= copy_idx_reg + 6'h01;
          prog_cnt_reg <= prog_cnt_reg + 32'h0000_0001;
          if (copy_idx_reg == 6'h20) begin
            p_reg <= P_WAIT;
          end
        end
        P_WAIT: begin
          prog_cnt_reg <= prog_cnt_reg + 32'h0000_0001;
          if (done_evt) begin
            p_reg <= P_IDLE;
          end
        end
        default: begin
          p_reg <= P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_reg <= 1'b0;
    end else if (wen_set) begin
      wen_reg <= 1'b1;
    end else if (wen_clr || done_evt) begin
      wen_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave
  assign ap        = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign int_set   = {refuse_evt, done_evt};
  assign irq       = |(int_stat_reg & int_mask_reg);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: begin
        rd_mux[CTRL_BP_LO_BIT] = bp_lo_reg;
        rd_mux[CTRL_BP_HI_BIT] = bp_hi_reg;
        rd_mux[CTRL_SWD_BIT]   = swd_reg;
      end
      OFS_STATUS: begin
        rd_mux[STS_BUSY_BIT] = busy;
        rd_mux[STS_WEN_BIT]  = wen_reg;
      end
      OFS_INT_STAT: rd_mux[1:0]    = int_stat_reg;
      OFS_INT_MASK: rd_mux[1:0]    = int_mask_reg;
      OFS_ARR_ADDR: rd_mux[AW-1:0] = arr_addr_reg;
      OFS_ARR_DATA: rd_mux[7:0]    = arr_rdata;
      default: begin
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      hrdata      <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ap && hwrite;
      wr_ofs_reg  <= haddr[7:0];
      hrdata      <= (ap && !hwrite) ? rd_mux : hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bp_lo_reg    <= CTRL_RESET;
      bp_hi_reg    <= CTRL_RESET;
      swd_reg      <= CTRL_RESET;
      int_mask_reg <= INT_MASK_RESET;
      int_stat_reg <= 2'h0;
      arr_addr_reg <= '0;
    end else begin
      int_stat_reg <= int_set | (int_stat_reg &
                      ~((wr_pend_reg && wr_ofs_reg == OFS_INT_STAT)
                        ? hwdata[1:0] : 2'h0));
      if (wr_pend_reg && wr_ofs_reg == OFS_CTRL) begin
        bp_lo_reg <= hwdata[CTRL_BP_LO_BIT];
        bp_hi_reg <= hwdata[CTRL_BP_HI_BIT];
        swd_reg   <= hwdata[CTRL_SWD_BIT];
      end
      if (wr_pend_reg && wr_ofs_reg == OFS_INT_MASK) begin
        int_mask_reg <= hwdata[1:0];
      end
      if (wr_pend_reg && wr_ofs_reg == OFS_ARR_ADDR) begin
        arr_addr_reg <= hwdata[AW-1:0];
      end
    end
  end

endmodule

//--- sim/spe_host.sv
// SPI host model driving select, clock and data of the write block
`timescale 1ns/10ps
module spe_host
  import spe_pkg::*;
(
  input  wire logic hclk,
  input  wire logic miso_o,
  input  wire logic miso_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  logic flip;
  logic line;
  // Undriven data line shows a changing pattern
  assign line = miso_oe_n ? flip : miso_o;
  initial begin
    flip = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  always @(posedge hclk) begin
    flip <= ~flip;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Four hclk a half period, link clock still between frames
  task automatic shift(input logic [7:0] b, input int n,
                       inout logic [7:0] r);
    for (int i = 7; i > 7 - n; i--) begin
      mosi <= b[i];
      wt(4);
      sclk <= 1'b1;
      wt(3);
      r[i] = line;
      wt(1);
      sclk <= 1'b0;
    end
  endtask
  // Whole bytes; cut below 8 stops the last byte early
  task automatic frame(input logic [7:0] q[$], input int cut,
                       output logic [7:0] r);
    r = 8'h00;
    wt(1);
    cs_n <= 1'b0;
    wt(4);
    foreach (q[k]) begin
      shift(q[k], (k == q.size() - 1) ? cut : 8, r);
    end
    wt(4);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    wt(6);
  endtask
endmodule

//--- sim/spe_properties.sv
// Port checks for the serial EEPROM write block
`timescale 1ns/10ps
module spe_properties
  import spe_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        mosi,
  input wire logic        miso_o,
  input wire logic        miso_oe_n,
  input wire logic        irq
);
  logic take;
  logic rd_take;
  logic wr_int;
  assign take    = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;
  assign wr_int  = take && hwrite && (haddr[7:0] == OFS_INT_STAT ||
                                      haddr[7:0] == OFS_INT_MASK);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_unmapped_zero: assert property
    (rd_take && haddr[7:0] == 8'h18 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_upper: assert property
    (rd_take && haddr[7:0] == OFS_STATUS |=> hrdata[31:2] == 30'h0)
    else $error("status upper bits set");
  a_rdata_stands: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("hrdata moved without read");
  a_irq_sticky: assert property ($fell(irq) |-> $past(wr_int, 2))
    else $error("irq fell without write");
  a_mask_clear: assert property
    (take && hwrite && haddr[7:0] == OFS_INT_MASK ##1 hwdata[1:0] == 2'h0
     |=> !irq)
    else $error("irq high with zero mask");
  a_quiet_undriven: assert property (miso_oe_n |-> miso_o == 1'b0)
    else $error("miso high while undriven");
  a_oe_in_frame: assert property (!miso_oe_n |-> !$past(cs_n, 6))
    else $error("miso driven outside frame");
endmodule
bind spe_top spe_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
  .miso_o(miso_o), .miso_oe_n(miso_oe_n), .irq(irq));

//--- sim/spe_top_tb.sv
// Self-checking bench for the serial EEPROM write block
`timescale 1ns/10ps
module spe_top_tb;
  import spe_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        sclk, cs_n, mosi, miso_o, miso_oe_n, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  spe_top #(.AW(ADDR_BITS), .PROG_CYC(400)) u_spe_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .irq(irq));
  spe_host u_host (.hclk(hclk), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask
  task automatic ist(input logic [1:0] e);
    rchk("int_stat", OFS_INT_STAT, {30'h0, e});
    wreg(OFS_INT_STAT, {30'h0, e});
  endtask
  task automatic mchk(input logic [10:0] a, input logic [7:0] e);
    wreg(OFS_ARR_ADDR, {21'h0, a});
    repeat (3) @(posedge hclk);
    rchk("array", OFS_ARR_DATA, {24'h0, e});
  endtask
  task automatic wr_enable;
    logic [7:0] r;
    u_host.frame('{CMD_WR_EN}, 8, r);
  endtask
  task automatic wr_frame(input logic [15:0] a, input logic [7:0] q[$],
                          input int cut);
    logic [7:0] r;
    q.push_front(a[7:0]);
    q.push_front(a[15:8]);
    q.push_front(CMD_WRITE);
    u_host.frame(q, cut, r);
  endtask
  task automatic wait_done;
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < 400 && r[0] !== 1'b0; i++) begin
      ahb(OFS_STATUS, 1'b0, 32'h0, r);
    end
    chk("busy_end", 32'h0, {31'h0, r[0]});
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic s_reset_state;
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("status", OFS_STATUS, 32'h0);
    rchk("int_mask", OFS_INT_MASK, 32'h0);
    wreg(8'h18, 32'hFFFFFFFF);
    rchk("unmapped", 8'h18, 32'h0);
    mchk(11'h000, ERASED_BYTE);
    mchk(11'h7FF, ERASED_BYTE);
  endtask
  task automatic s_no_enable;
    logic [7:0] r;
    wr_enable();
    u_host.frame('{CMD_WRDIS}, 8, r);
    rchk("status", OFS_STATUS, 32'h0);
    wr_frame(16'h0040, '{8'h5A}, 8);
    wreg(OFS_INT_MASK, 32'h3);
    @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    ist(2'h2);
    @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    wreg(OFS_INT_MASK, 32'h0);
    mchk(11'h040, ERASED_BYTE);
  endtask
  task automatic s_byte;
    logic [7:0] r;
    wr_enable();
    rchk("status", OFS_STATUS, 32'h2);
    wr_frame(16'h0123, '{8'h3C}, 8);
    rchk("status", OFS_STATUS, 32'h3);
    u_host.frame('{CMD_RDST, 8'h00}, 8, r);
    chk("spi_status", 32'h3, {24'h0, r});
    wait_done();
    rchk("status", OFS_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    ist(2'h1);
    mchk(11'h123, 8'h3C);
    mchk(11'h124, ERASED_BYTE);
  endtask
  task automatic s_page_wrap;
    logic [7:0] q[$];
    for (int k = 0; k < 34; k++) begin
      q.push_back(8'h40 + 8'(k));
    end
    wr_enable();
    wr_frame(16'hFC3E, q, 8);
    wait_done();
    mchk(11'h43E, 8'h60);
    mchk(11'h43F, 8'h61);
    mchk(11'h420, 8'h42);
    mchk(11'h43D, 8'h5F);
    mchk(11'h440, ERASED_BYTE);
  endtask
  task automatic s_busy;
    wr_enable();
    wr_frame(16'h0200, '{8'h11}, 8);
    wr_frame(16'h0201, '{8'h22}, 8);
    wait_done();
    ist(2'h3);
    mchk(11'h200, 8'h11);
    mchk(11'h201, ERASED_BYTE);
  endtask
  task automatic s_abort;
    logic [31:0] r;
    wr_enable();
    wr_frame(16'h0050, '{8'h77, 8'h88}, 4);
    ahb(OFS_STATUS, 1'b0, 32'h0, r);
    chk("busy", 32'h0, {31'h0, r[0]});
    ist(2'h2);
    mchk(11'h050, ERASED_BYTE);
  endtask
  task automatic s_protect;
    for (int b = 1; b < 4; b++) begin
      wreg(OFS_CTRL, 32'(b));
      rchk("ctrl", OFS_CTRL, 32'(b));
      wr_enable();
      wr_frame(16'h07E0, '{8'h99}, 8);
      ist(2'h2);
      mchk(11'h7E0, ERASED_BYTE);
    end
    wreg(OFS_CTRL, 32'h2);
    wr_enable();
    wr_frame(16'h03E0, '{8'h5A}, 8);
    wait_done();
    mchk(11'h3E0, 8'h5A);
    wreg(OFS_CTRL, 32'h0);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    s_reset_state();
    s_no_enable();
    s_byte();
    s_page_wrap();
    s_busy();
    s_abort();
    s_protect();
    results();
  end
endmodule
